// >>> core/ioxc_pkg.sv
// package: constants and types shared by the i2c io expander core
package ioxc_pkg;
    localparam int          NLINES     = 8;      // io lines
    localparam int          GROUP      = 4;      // lines per pullup / default group
    localparam logic [2:0]  ADDR_FIXED = 3'h6;   // slave address bits a6..a4 = 110
    localparam logic [3:0]  BIT_LAST   = 4'h8;   // bits of a byte before acknowledge
    localparam logic [3:0]  BIT_MSB    = 4'h7;   // last data bit index while sending
    localparam logic [1:0]  INIT_WAIT  = 2'h2;   // strap synchroniser settle cycles
    localparam logic [1:0]  WR_SETTLE  = 2'h3;   // cycles from a write until the pins read back through the synchroniser

    // resolved connection of an address-select input
    typedef enum logic [1:0] {IOXC_LOW, IOXC_HIGH, IOXC_SCL, IOXC_SDA} ioxc_lvl_t;

    // slave interface states
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} ioxc_st_t;

    // serial bus pin pair
    typedef struct packed {
        logic scl;
        logic sda;
    } ioxc_bus_t;

    // address bits a3:a2 from the high select input
    function automatic logic [1:0] ioxc_hi_bits(input ioxc_lvl_t l);
        unique case (l)
            IOXC_SCL:  return 2'h0;
            IOXC_SDA:  return 2'h1;
            IOXC_LOW:  return 2'h2;
            IOXC_HIGH: return 2'h3;
        endcase
    endfunction

    // address bits a1:a0 from the low select input
    function automatic logic [1:0] ioxc_lo_bits(input ioxc_lvl_t l);
        unique case (l)
            IOXC_LOW:  return 2'h0;
            IOXC_HIGH: return 2'h1;
            IOXC_SCL:  return 2'h2;
            IOXC_SDA:  return 2'h3;
        endcase
    endfunction
endpackage

// >>> core/ioxc_core.sv
// i2c io expander core: serial slave on the link clock, port logic on the system clock
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - after reset transition detection cleared, alert released, all flags zero
// - low select sets defaults and pullups of lines 3-0, high select lines 7-4
// - select high, sda or scl: pullups on, default high; select low: off, low
// - during power-on clear all lines are released and serial interface is idle
// - bus abort cancels any transaction and returns slave to post-stop idle
// - bus abort leaves the latched alert state alone; like stop, it ends a read's quiet hold on the alert output
// - answer only addresses 110xxxx, low four bits from the select inputs
// - every transmission re-decodes each select as low, high, sda or scl
// - a3:a2 scl 00 sda 01 low 10 high 11; a1:a0 low 00 high 01 scl 10 sda 11
// - before first transmission selects resolve only as high or low
// - released line differing from snapshot sets its flag and latches alert low
// - on access acknowledge load snapshot from lines and clear old flags
// - read returns line levels first, previous flags second
// - written byte sets all eight outputs, bit n to line n
// - acknowledging own address releases alert and clears flags
// - longer reads alternate fresh levels and flags, resampling each time
// - no alert during a read; it comes back after stop
// - written high means released; writes themselves raise no alert
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module ioxc_core
    import ioxc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_link_clk,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output var  logic              o_sda_out,
    output var  logic              o_sda_oe_n,
    input  wire logic              i_bus_abort,
    input  wire logic              i_addr_sel_low,
    input  wire logic              i_addr_sel_high,
    input  wire logic [NLINES-1:0] i_io_lines,
    output var  logic [NLINES-1:0] o_io_lines_out,
    output var  logic [NLINES-1:0] o_io_lines_oe_n,
    output var  logic [NLINES-1:0] o_pullup_en,
    output var  logic              o_alert_out,
    output var  logic              o_alert_oe_n
);
    //////////////////////////////////////////////////////////////////////////
    // link domain
    ioxc_bus_t         bus_m_r, bus_s_r, bus_d_r;
    logic [1:0]        sel_m_r, sel_s_r, sel_d_r;
    logic              abort_m_r, abort_s_r;
    logic [NLINES-1:0] lvl_lm_r, lvl_ls_r;
    logic              done_m_r, done_s_r, done_d_r;
    ioxc_st_t          st_r;
    logic [3:0]        cnt_r;
    logic [7:0]        sh_r, tx_r, wr_data_r, flags_hold_r;
    logic              rw_r, rd_sel_r, rd_act_r, snap_tgl_r, wr_tgl_r, decoded_r;
    logic [NLINES-1:0] prev_flags_r;                                       // system domain, read back here
    logic              done_tgl_r;                                         // system domain, answers the snapshot toggle
    ioxc_lvl_t         code_r [2];
    ioxc_lvl_t         dec [2];
    logic [1:0]        mm_scl_r, mm_sda_r, seen_hi_r, seen_lo_r;
    logic              scl_rise, scl_fall, start_c, stop_c, addr_end;
    logic [6:0]        my_addr;

    // pins settle through two flops; the third stage only feeds edge detection
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_m_r   <= '1;
            bus_s_r   <= '1;
            bus_d_r   <= '1;
            sel_m_r   <= '0;
            sel_s_r   <= '0;
            sel_d_r   <= '0;
            abort_m_r <= 1'b0;
            abort_s_r <= 1'b0;
            lvl_lm_r  <= '0;
            lvl_ls_r  <= '0;
            done_m_r  <= 1'b0;
            done_s_r  <= 1'b0;
            done_d_r  <= 1'b0;
        end else begin
            bus_m_r   <= '{scl: i_scl, sda: i_sda};
            bus_s_r   <= bus_m_r;
            bus_d_r   <= bus_s_r;
            sel_m_r   <= {i_addr_sel_high, i_addr_sel_low};
            sel_s_r   <= sel_m_r;
            sel_d_r   <= sel_s_r;
            abort_m_r <= i_bus_abort;
            abort_s_r <= abort_m_r;
            lvl_lm_r  <= i_io_lines;
            lvl_ls_r  <= lvl_lm_r;
            done_m_r  <= done_tgl_r;
            done_s_r  <= done_m_r;
            done_d_r  <= done_s_r;
        end
    end

    // bus events
    assign scl_rise = bus_s_r.scl & ~bus_d_r.scl;
    assign scl_fall = ~bus_s_r.scl & bus_d_r.scl;
    assign start_c  = bus_s_r.scl & bus_d_r.scl & bus_d_r.sda & ~bus_s_r.sda;
    assign stop_c   = bus_s_r.scl & bus_d_r.scl & ~bus_d_r.sda & bus_s_r.sda;
    assign addr_end = (st_r == ST_ADDR) && scl_fall && (cnt_r == BIT_LAST);
    assign my_addr  = {ADDR_FIXED, ioxc_hi_bits(dec[1]), ioxc_lo_bits(dec[0])};

    // per select input: watch it against the bus lines during the address byte
    for (genvar k = 0; k < 2; k++) begin : g_sel
        always_ff @(posedge i_link_clk or posedge i_rst) begin
            if (i_rst) begin
                mm_scl_r[k]  <= 1'b0;
                mm_sda_r[k]  <= 1'b0;
                seen_hi_r[k] <= 1'b0;
                seen_lo_r[k] <= 1'b0;
            end else if (start_c) begin
                mm_scl_r[k]  <= 1'b0;
                mm_sda_r[k]  <= 1'b0;
                seen_hi_r[k] <= 1'b0;
                seen_lo_r[k] <= 1'b0;
            end else if (st_r == ST_ADDR && sel_s_r[k] == sel_d_r[k]) begin
                // compare only while both are steady, so edge skew does not count
                if (bus_s_r.scl == bus_d_r.scl && sel_s_r[k] != bus_s_r.scl) begin
                    mm_scl_r[k] <= 1'b1;
                end
                if (bus_s_r.sda == bus_d_r.sda && sel_s_r[k] != bus_s_r.sda) begin
                    mm_sda_r[k] <= 1'b1;
                end
                seen_hi_r[k] <= seen_hi_r[k] | sel_s_r[k];
                seen_lo_r[k] <= seen_lo_r[k] | ~sel_s_r[k];
            end
        end

        // four-level decision; an unclear input counts as high
        always_comb begin
            if (seen_hi_r[k] && seen_lo_r[k] && !mm_scl_r[k]) begin
                dec[k] = IOXC_SCL;
            end else if (seen_hi_r[k] && seen_lo_r[k] && !mm_sda_r[k]) begin
                dec[k] = IOXC_SDA;
            end else if (seen_lo_r[k] && !seen_hi_r[k]) begin
                dec[k] = IOXC_LOW;
            end else begin
                dec[k] = IOXC_HIGH;
            end
        end

        // resolved code: plain level until the first transmission, decoded after
        always_ff @(posedge i_link_clk or posedge i_rst) begin
            if (i_rst) begin
                code_r[k] <= IOXC_HIGH;
            end else if (addr_end) begin
                code_r[k] <= dec[k];
            end else if (!decoded_r) begin
                code_r[k] <= sel_s_r[k] ? IOXC_HIGH : IOXC_LOW;
            end
        end

        // pullups per group of four
        always_ff @(posedge i_link_clk or posedge i_rst) begin
            if (i_rst) begin
                o_pullup_en[k*GROUP +: GROUP] <= '0;
            end else begin
                o_pullup_en[k*GROUP +: GROUP] <= {GROUP{code_r[k] != IOXC_LOW}};
            end
        end
    end

    // serial slave engine
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r       <= ST_IDLE;
            cnt_r      <= '0;
            sh_r       <= '0;
            tx_r       <= '0;
            rw_r       <= 1'b0;
            rd_sel_r   <= 1'b0;
            rd_act_r   <= 1'b0;
            snap_tgl_r <= 1'b0;
            wr_tgl_r   <= 1'b0;
            wr_data_r  <= '0;
            decoded_r  <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (abort_s_r || stop_c) begin
            st_r       <= ST_IDLE;
            rd_act_r   <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (start_c) begin
            st_r       <= ST_ADDR;
            cnt_r      <= '0;
            rd_act_r   <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_r  <= {sh_r[6:0], bus_s_r.sda};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == BIT_LAST) begin
                        cnt_r <= '0;
                        if (st_r == ST_WR) begin
                            o_sda_oe_n <= 1'b0;
                            st_r       <= ST_WR_ACK;
                            wr_data_r  <= sh_r;
                            wr_tgl_r   <= ~wr_tgl_r;
                        end else begin
                            decoded_r <= 1'b1;
                            if (sh_r[7:1] == my_addr) begin
                                o_sda_oe_n <= 1'b0;
                                st_r       <= ST_ADDR_ACK;
                                rw_r       <= sh_r[0];
                                rd_act_r   <= sh_r[0];
                                rd_sel_r   <= 1'b1;
                                snap_tgl_r <= ~snap_tgl_r;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_rise) begin
                        tx_r <= lvl_ls_r;
                    end else if (scl_fall) begin
                        cnt_r      <= '0;
                        st_r       <= rw_r ? ST_RD : ST_WR;
                        o_sda_oe_n <= rw_r ? tx_r[7] : 1'b1;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        o_sda_oe_n <= 1'b1;
                        st_r       <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_r == BIT_MSB) begin
                            o_sda_oe_n <= 1'b1;
                            st_r       <= ST_RD_ACK;
                        end else begin
                            o_sda_oe_n <= tx_r[6];
                            tx_r       <= {tx_r[6:0], 1'b0};
                            cnt_r      <= cnt_r + 4'h1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (bus_s_r.sda) begin
                            st_r <= ST_IDLE;                               // master ends the read
                        end else if (rd_sel_r) begin
                            tx_r     <= flags_hold_r;
                            rd_sel_r <= 1'b0;
                        end else begin
                            tx_r       <= lvl_ls_r;
                            rd_sel_r   <= 1'b1;
                            snap_tgl_r <= ~snap_tgl_r;
                        end
                    end else if (scl_fall) begin
                        cnt_r      <= '0;
                        st_r       <= ST_RD;
                        o_sda_oe_n <= tx_r[7];
                    end
                end
            endcase
        end
    end

    // previous flags are steady once the answering toggle arrives
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_hold_r <= '0;
            o_sda_out    <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
            if (done_s_r != done_d_r) begin
                flags_hold_r <= prev_flags_r;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // system domain
    logic [NLINES-1:0] lvl_m_r, lvl_s_r, snap_r, flags_r, out_r, chg;
    logic [1:0]        wr_hold_r;
    logic [1:0]        psel_m_r, psel_s_r;
    logic              snp_m_r, snp_s_r, snp_d_r, wrt_m_r, wrt_s_r, wrt_d_r;
    logic              rda_m_r, rda_s_r, init_done_r;
    logic [1:0]        init_cnt_r;
    logic              snap_evt, wr_evt;

    // synchronisers into the system clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lvl_m_r  <= '0;
            lvl_s_r  <= '0;
            psel_m_r <= '0;
            psel_s_r <= '0;
            snp_m_r  <= 1'b0;
            snp_s_r  <= 1'b0;
            snp_d_r  <= 1'b0;
            wrt_m_r  <= 1'b0;
            wrt_s_r  <= 1'b0;
            wrt_d_r  <= 1'b0;
            rda_m_r  <= 1'b0;
            rda_s_r  <= 1'b0;
        end else begin
            lvl_m_r  <= i_io_lines;
            lvl_s_r  <= lvl_m_r;
            psel_m_r <= {i_addr_sel_high, i_addr_sel_low};
            psel_s_r <= psel_m_r;
            snp_m_r  <= snap_tgl_r;
            snp_s_r  <= snp_m_r;
            snp_d_r  <= snp_s_r;
            wrt_m_r  <= wr_tgl_r;
            wrt_s_r  <= wrt_m_r;
            wrt_d_r  <= wrt_s_r;
            rda_m_r  <= rd_act_r;
            rda_s_r  <= rda_m_r;
        end
    end

    assign snap_evt = snp_s_r != snp_d_r;
    assign wr_evt   = wrt_s_r != wrt_d_r;
    assign chg      = (lvl_s_r ^ snap_r) & out_r & {NLINES{init_done_r && wr_hold_r == 2'h0}};

    // a released line reaches the synchroniser a few cycles after the write; ignore it until then
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_hold_r <= '0;
        end else if (wr_evt) begin
            wr_hold_r <= WR_SETTLE;
        end else if (wr_hold_r != 2'h0) begin
            wr_hold_r <= wr_hold_r - 2'h1;
        end
    end

    // straps are caught after release, once their synchroniser has settled
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            init_cnt_r  <= '0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            init_cnt_r  <= init_cnt_r + 2'h1;
            init_done_r <= init_cnt_r == INIT_WAIT;
        end
    end

    // output register; lines stay released while power-on clear holds
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_r <= '1;
        end else if (!init_done_r && init_cnt_r == INIT_WAIT) begin
            out_r <= {{GROUP{psel_s_r[1]}}, {GROUP{psel_s_r[0]}}};
        end else if (wr_evt) begin
            out_r <= wr_data_r;
        end
    end

    // snapshot; a line released by a write is expected high, not a change
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            snap_r <= '0;
        end else if (snap_evt || !init_done_r) begin
            snap_r <= lvl_s_r;
        end else if (wr_evt) begin
            snap_r <= snap_r | (wr_data_r & ~out_r);
        end
    end

    // transition flags; the new snapshot equals the lines so no change is lost
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_r      <= '0;
            prev_flags_r <= '0;
            done_tgl_r   <= 1'b0;
        end else if (snap_evt) begin
            prev_flags_r <= flags_r;
            flags_r      <= '0;
            done_tgl_r   <= snp_s_r;
        end else begin
            flags_r <= flags_r | chg;
        end
    end

    // latched alert, held quiet through a read; the abort input reaches it only by ending a read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_alert_oe_n    <= 1'b1;
            o_alert_out     <= 1'b0;
            o_io_lines_out  <= '0;
            o_io_lines_oe_n <= '1;
        end else begin
            o_alert_oe_n    <= ~(|flags_r & ~rda_s_r);
            o_alert_out     <= 1'b0;
            o_io_lines_out  <= '0;
            o_io_lines_oe_n <= out_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // assertions
    alert_on_change_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (|chg && !snap_evt) ##1 (!snap_evt && !rda_s_r) |=> !o_alert_oe_n)
        else $error("line change did not raise alert");
    flags_clear_ack_a: assert property (@(posedge i_clk) disable iff (i_rst)
        snap_evt |=> flags_r == '0 ##1 (rda_s_r || o_alert_oe_n))
        else $error("flags not cleared on acknowledge");
    snapshot_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        snap_evt |=> snap_r == $past(lvl_s_r) && prev_flags_r == $past(flags_r))
        else $error("snapshot not loaded");
    write_apply_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_evt |=> out_r == $past(wr_data_r) ##1 o_io_lines_oe_n == $past(wr_data_r, 2))
        else $error("written byte not applied");
    flag_needs_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (flags_r & ~$past(flags_r) & ~$past(out_r)) == '0)
        else $error("flag set on driven line");
    read_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (rda_s_r && $past(rda_s_r)) |-> o_alert_oe_n)
        else $error("alert asserted during read");
    abort_idle_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
        abort_s_r |=> st_r == ST_IDLE && o_sda_oe_n)
        else $error("abort did not idle the slave");
    addr_ack_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
        (addr_end && sh_r[7:1] == my_addr) |=> !o_sda_oe_n && st_r == ST_ADDR_ACK)
        else $error("own address not acknowledged");
    pullup_low_a: assert property (@(posedge i_link_clk) disable iff (i_rst)
        code_r[0] == IOXC_LOW |=> o_pullup_en[GROUP-1:0] == '0)
        else $error("pullups on for low select");
    read_seen_c: cover property (@(posedge i_link_clk) disable iff (i_rst)
        st_r == ST_RD_ACK ##1 st_r == ST_RD);
    write_seen_c: cover property (@(posedge i_clk) disable iff (i_rst) wr_evt);
    abort_seen_c: cover property (@(posedge i_link_clk) disable iff (i_rst)
        abort_s_r && st_r != ST_IDLE);
endmodule // ioxc_core
`default_nettype wire

// >>> sim/ioxc_master.sv
// serial bus master model driving the expander core
`timescale 1ns/10ps
`default_nettype none
module ioxc_master (
    input  wire logic i_link_clk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda
);
    // idle bus is released high on both lines
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // half bit: 5 link cycles, above the 4-cycle minimum; moves on the falling edge to avoid races
    task automatic half();
        repeat (5) @(negedge i_link_clk);
    endtask
    // start also serves as a repeated start
    task automatic start();
        o_sda = 1'b1; half(); o_scl = 1'b1; half(); o_sda = 1'b0; half(); o_scl = 1'b0;
    endtask
    task automatic stop();
        o_sda = 1'b0; half(); o_scl = 1'b1; half(); o_sda = 1'b1; half();
    endtask
    // one clock pulse; the wire is sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        o_sda = b; half(); o_scl = 1'b1; half(); r = i_sda; o_scl = 1'b0;
    endtask
    // eight bits msb first, then the ninth bit; whole bytes only
    task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a9, ak);
    endtask
endmodule // ioxc_master
`default_nettype wire

// >>> sim/i2c_io_expander_core_tb.sv
// self-checking bench for the expander core
`timescale 1ns/10ps
`default_nettype none
module i2c_io_expander_core_tb;
    import ioxc_pkg::*;
    logic       clk = 0, lclk = 0, rst = 1, abort = 0, lo_sda = 0, lo_lvl = 1;
    logic       m_scl, m_sda, sda_oe_n, alert_oe_n, ack, sda, sel_lo;
    logic [7:0] ext = 8'hFF, oe_n, pu, lv, fl;
    int         bad_count = 0, compares = 0;
    // wired-and bus; low select strap can be tied to the data wire
    assign sda    = m_sda & sda_oe_n;
    assign sel_lo = lo_sda ? sda : lo_lvl;
    initial forever #4 clk = ~clk;
    initial begin #37; forever #80 lclk = ~lclk; end
    ioxc_master mst (.i_link_clk(lclk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    ioxc_core uut (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_scl(m_scl), .i_sda(sda), .o_sda_out(),
        .o_sda_oe_n(sda_oe_n), .i_bus_abort(abort), .i_addr_sel_low(sel_lo), .i_addr_sel_high(1'b0),
        .i_io_lines(oe_n & ext), .o_io_lines_out(), .o_io_lines_oe_n(oe_n), .o_pullup_en(pu),
        .o_alert_out(), .o_alert_oe_n(alert_oe_n));
    //////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // bounded wait on the alert level
    task automatic wait_alert(input logic lvl);
        int n = 0;
        while (alert_oe_n !== lvl && n < 400) begin @(negedge clk); n++; end
        chk({7'h0, alert_oe_n}, {7'h0, lvl}, "alert level");
        if (n == 400) print_verdict();
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic ak);
        logic [7:0] x;
        logic       k;
        mst.start(); mst.xfer({a, 1'b0}, 1'b1, x, ak); mst.xfer(d, 1'b1, x, k); mst.stop();
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] x;
        repeat (16) @(negedge clk);
        rst = 0;
        repeat (200) @(negedge clk);
        chk(oe_n, 8'h0F, "power-up levels");
        chk(pu, 8'h0F, "pullup groups");
        chk({7'h0, alert_oe_n}, 8'h01, "alert after reset");
        wr(7'h69, 8'hF5, ack); chk({7'h0, ack}, 8'h00, "own address ack");
        repeat (20) @(negedge clk);
        chk(oe_n, 8'hF5, "written lines");
        chk({7'h0, alert_oe_n}, 8'h01, "write raises no alert");
        // pull released line 0 low from outside
        ext = 8'hFE;
        wait_alert(1'b0);
        mst.start(); mst.xfer({7'h69, 1'b1}, 1'b1, x, ack);
        mst.xfer(8'hFF, 1'b0, lv, ack); mst.xfer(8'hFF, 1'b1, fl, ack); mst.stop();
        chk(lv, 8'hF4, "levels byte");
        chk(fl, 8'h01, "flags byte");
        wait_alert(1'b1);
        wr(7'h68, 8'h00, ack); chk({7'h0, ack}, 8'h01, "foreign address");
        chk(oe_n, 8'hF5, "foreign write ignored");
        // alert raised inside a write, then the transaction is aborted
        mst.start(); mst.xfer({7'h69, 1'b0}, 1'b1, x, ack);
        @(negedge clk) ext = 8'hFF;
        wait_alert(1'b0);
        @(negedge clk) abort = 1;
        repeat (100) @(negedge clk);
        abort = 0;
        repeat (100) @(negedge clk);
        chk({7'h0, alert_oe_n}, 8'h00, "abort keeps alert");
        mst.xfer(8'h00, 1'b1, x, ack); mst.stop();
        chk(oe_n, 8'hF5, "aborted write ignored");
        // low select now tied to the data wire; any transmission re-decodes it
        @(negedge clk) lo_sda = 1;
        wr(7'h60, 8'h00, ack);
        wr(7'h6B, 8'hAA, ack); chk({7'h0, ack}, 8'h00, "data-tied address");
        repeat (20) @(negedge clk);
        chk(oe_n, 8'hAA, "lines after re-decode");
        chk(pu, 8'h0F, "data-tied pullups");
        print_verdict();
    end
endmodule // i2c_io_expander_core_tb
`default_nettype wire
